// >>> hw/glhp_pkg.sv
// package with constants for the graphic lcd host port
package glhp_pkg;
  localparam int          DATA_W        = 8;
  localparam int          PAGE_W        = 3;
  localparam int          COL_W         = 6;
  localparam int          LINE_W        = 6;
  localparam int          RAM_DEPTH     = 512;
  localparam int          ADDR_W        = 9;
  // internal operation length after an accepted access
  localparam int          OP_TIME_NS    = 500;
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OP_CNT_W      = 4;
  // status bit positions
  localparam int          STAT_BUSY_BIT  = 7;
  localparam int          STAT_OFF_BIT   = 5;
  localparam int          STAT_RESET_BIT = 4;
  // reset values
  localparam logic [5:0]  LINE_RST      = 6'h00;
  localparam logic [5:0]  COL_RST       = 6'h00;
  localparam logic [2:0]  PAGE_RST      = 3'h0;
  // instruction opcodes
  localparam logic [6:0]  OP_DISP       = 7'h1f;
  localparam logic [1:0]  OP_COL        = 2'h1;
  localparam logic [4:0]  OP_PAGE       = 5'h17;
  localparam logic [1:0]  OP_LINE       = 2'h3;

  typedef enum logic [1:0] {
    GLHP_INSTR_WR = 2'b00,
    GLHP_STAT_RD  = 2'b01,
    GLHP_DATA_WR  = 2'b10,
    GLHP_DATA_RD  = 2'b11
  } glhp_access_t;
endpackage

// >>> hw/glhp_ram.sv
// display data ram, one write and one read port
`timescale 1ns/1ns
module glhp_ram #(
  parameter int DEPTH = 512,
  parameter int AW    = 9,
  parameter int DW    = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// >>> hw/glhp_busy.sv
// busy timer: holds busy for a fixed count after each start
`timescale 1ns/1ns
module glhp_busy #(
  parameter int CYCLES = 10,
  parameter int CW     = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= CW'(CYCLES);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == CW'(1));
endmodule

// >>> hw/glhp_host_port.sv
// host port of one column driver: decode, status, addressing, ram and scroll
`timescale 1ns/1ns
module glhp_host_port #(
  parameter int OP_CYCLES = glhp_pkg::OP_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        reset_n_pin,
  input  wire logic                        chip_select_a,
  input  wire logic                        chip_select_b,
  input  wire logic                        register_select,
  input  wire logic                        read_write,
  input  wire logic                        enable_strobe,
  input  wire logic [glhp_pkg::DATA_W-1:0] bus_in,
  output logic      [glhp_pkg::DATA_W-1:0] bus_out,
  output logic                             bus_oe,
  input  wire logic                        column_order,
  input  wire logic                        frame_sync,
  input  wire logic [glhp_pkg::PAGE_W-1:0] scan_page,
  input  wire logic [glhp_pkg::COL_W-1:0]  scan_col,
  output logic      [glhp_pkg::DATA_W-1:0] seg_data,
  output logic      [glhp_pkg::LINE_W-1:0] row_addr,
  output logic                             display_off
);
  typedef glhp_pkg::glhp_access_t glhp_access_t;

  logic                        strobe_d_ff;
  logic                        strobe_fall;
  logic                        selected;
  glhp_access_t                acc;
  logic                        busy;
  logic                        op_done;
  logic                        accept;
  logic                        in_reset;
  logic [glhp_pkg::DATA_W-1:0] in_reg_ff;
  logic                        pend_wr_ff;
  logic [glhp_pkg::ADDR_W-1:0] pend_addr_ff;
  logic [glhp_pkg::DATA_W-1:0] out_reg_ff;
  logic                        off_ff;
  logic [glhp_pkg::PAGE_W-1:0] page_ff;
  logic [glhp_pkg::COL_W-1:0]  col_ff;
  logic [glhp_pkg::LINE_W-1:0] line_ff;
  logic [glhp_pkg::LINE_W-1:0] row_ff;
  logic [glhp_pkg::DATA_W-1:0] seg_ff;
  logic [glhp_pkg::DATA_W-1:0] status_word;
  logic [glhp_pkg::DATA_W-1:0] ram_rd_data;
  logic [glhp_pkg::DATA_W-1:0] scan_rd_data;
  logic [glhp_pkg::ADDR_W-1:0] cur_addr;
  logic [glhp_pkg::COL_W-1:0]  scan_col_eff;
  logic                        instr_wr;
  logic                        data_acc;

  function automatic logic [glhp_pkg::ADDR_W-1:0] ram_addr(
    input logic [glhp_pkg::PAGE_W-1:0] pg,
    input logic [glhp_pkg::COL_W-1:0]  cl
  );
    ram_addr = {pg, cl};
  endfunction

  // strobe edge detector: every access except a status read is taken on the falling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d_ff <= 1'b0;
    end else begin
      strobe_d_ff <= enable_strobe;
    end
  end

  assign strobe_fall = ~enable_strobe & strobe_d_ff;
  assign selected    = chip_select_a & chip_select_b;
  assign acc         = glhp_access_t'({register_select, read_write});
  assign in_reset    = ~reset_n_pin;

  // data reads latch at the end of the strobe too, so the bus keeps
  // showing the earlier byte for the whole strobe high time
  always_comb begin
    accept = 1'b0;
    if (selected && !busy && !in_reset) begin
      unique case (acc)
        glhp_access_t'(glhp_pkg::GLHP_INSTR_WR): accept = strobe_fall;
        glhp_access_t'(glhp_pkg::GLHP_DATA_WR):  accept = strobe_fall;
        glhp_access_t'(glhp_pkg::GLHP_DATA_RD):  accept = strobe_fall;
        glhp_access_t'(glhp_pkg::GLHP_STAT_RD):  accept = 1'b0;
      endcase
    end
  end

  assign instr_wr = accept && (acc == glhp_pkg::GLHP_INSTR_WR);
  assign data_acc = accept && (acc != glhp_pkg::GLHP_INSTR_WR);
  assign cur_addr = ram_addr(page_ff, col_ff);

  glhp_busy #(
    .CYCLES (OP_CYCLES),
    .CW     (glhp_pkg::OP_CNT_W)
  ) u_busy (
    .clk   (clk),
    .rst_n (rst_n),
    .start (accept),
    .busy  (busy),
    .done  (op_done)
  );

  // input register and deferred ram write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_reg_ff    <= '0;
      pend_wr_ff   <= 1'b0;
      pend_addr_ff <= '0;
    end else if (accept && acc == glhp_pkg::GLHP_DATA_WR) begin
      in_reg_ff    <= bus_in;
      pend_wr_ff   <= 1'b1;
      pend_addr_ff <= cur_addr;
    end else if (op_done) begin
      pend_wr_ff   <= 1'b0;
    end
  end

  glhp_ram #(
    .DEPTH (glhp_pkg::RAM_DEPTH),
    .AW    (glhp_pkg::ADDR_W),
    .DW    (glhp_pkg::DATA_W)
  ) u_ram (
    .clk     (clk),
    .wr_en   (pend_wr_ff & op_done),
    .wr_addr (pend_addr_ff),
    .wr_data (in_reg_ff),
    .rd_addr (cur_addr),
    .rd_data (ram_rd_data)
  );

  // output register keeps the byte for the next read (dummy read first)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg_ff <= '0;
    end else if (accept && acc == glhp_pkg::GLHP_DATA_RD) begin
      out_reg_ff <= ram_rd_data;
    end
  end

  // display off flip-flop, set by reset pin, otherwise only by instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_ff <= 1'b1;
    end else if (in_reset) begin
      off_ff <= 1'b1;
    end else if (instr_wr && bus_in[7:1] == glhp_pkg::OP_DISP) begin
      off_ff <= ~bus_in[0];
    end
  end

  // page register: load only, no counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_ff <= glhp_pkg::PAGE_RST;
    end else if (instr_wr && bus_in[7:3] == glhp_pkg::OP_PAGE) begin
      page_ff <= bus_in[2:0];
    end
  end

  // column counter: load, then +1 per data access with natural wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_ff <= glhp_pkg::COL_RST;
    end else if (instr_wr && bus_in[7:6] == glhp_pkg::OP_COL) begin
      col_ff <= bus_in[5:0];
    end else if (data_acc) begin
      col_ff <= col_ff + {{(glhp_pkg::COL_W-1){1'b0}}, 1'b1};
    end
  end

  // scroll start line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_ff <= glhp_pkg::LINE_RST;
    end else if (in_reset) begin
      line_ff <= glhp_pkg::LINE_RST;
    end else if (instr_wr && bus_in[7:6] == glhp_pkg::OP_LINE) begin
      line_ff <= bus_in[5:0];
    end
  end

  // row counter preset from the start line while frame is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_ff <= glhp_pkg::LINE_RST;
    end else if (frame_sync) begin
      row_ff <= line_ff;
    end
  end

  // column order pin mirrors the scan column, independent of selects
  assign scan_col_eff = column_order ? ~scan_col : scan_col;

  glhp_ram #(
    .DEPTH (glhp_pkg::RAM_DEPTH),
    .AW    (glhp_pkg::ADDR_W),
    .DW    (glhp_pkg::DATA_W)
  ) u_scan_ram (
    .clk     (clk),
    .wr_en   (pend_wr_ff & op_done),
    .wr_addr (pend_addr_ff),
    .wr_data (in_reg_ff),
    .rd_addr (ram_addr(scan_page, scan_col_eff)),
    .rd_data (scan_rd_data)
  );

  // segment data: one is lit; off or reset forces all unlit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_ff <= '0;
    end else if (off_ff || in_reset) begin
      seg_ff <= '0;
    end else begin
      seg_ff <= scan_rd_data;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[glhp_pkg::STAT_BUSY_BIT]  = busy;
    status_word[glhp_pkg::STAT_OFF_BIT]   = off_ff;
    status_word[glhp_pkg::STAT_RESET_BIT] = in_reset;
  end

  // read data drive: status is live, data read shows output register
  assign bus_oe  = selected & read_write & enable_strobe;
  assign bus_out = register_select ? out_reg_ff : status_word;

  assign seg_data    = seg_ff;
  assign row_addr    = row_ff;
  assign display_off = off_ff;
endmodule

// >>> bench/glhp_host_model.sv
// host processor model driving the strobe bus of the port
`timescale 1ns/1ns
module glhp_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_out,
  output logic            chip_select_a,
  output logic            chip_select_b,
  output logic            register_select,
  output logic            read_write,
  output logic            enable_strobe,
  output logic      [7:0] bus_in
);
  initial begin
    chip_select_a = 1'b0;
    chip_select_b = 1'b0;
    register_select = 1'b0;
    read_write = 1'b0;
    enable_strobe = 1'b0;
    bus_in = 8'h00;
  end

  // setup 9 cycles, strobe high 10 cycles, full cycle 20 cycles
  // released data lines show the inverse of the last value
  task automatic acc(input logic sel, input logic rs, input logic rw,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    chip_select_a <= 1'b1;
    chip_select_b <= sel;
    register_select <= rs;
    read_write <= rw;
    bus_in <= rw ? ~bus_in : d;
    repeat (9) @(posedge clk);
    enable_strobe <= 1'b1;
    // read data taken once settled, early in the strobe high time
    @(negedge clk);
    q = bus_out;
    repeat (10) @(posedge clk);
    enable_strobe <= 1'b0;
  endtask

  // status polling until ready and out of reset
  task automatic poll(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      acc(1'b1, 1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0) && (s[4] === 1'b0);
    end
  endtask
endmodule

// >>> bench/glhp_host_port_sva.sv
// concurrent checks on the host port pins
`timescale 1ns/1ns
module glhp_host_port_sva #(
  parameter int OP_CYCLES = glhp_pkg::OP_CYCLES
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reset_n_pin,
  input wire logic       chip_select_a,
  input wire logic       chip_select_b,
  input wire logic       register_select,
  input wire logic       read_write,
  input wire logic       enable_strobe,
  input wire logic [7:0] bus_out,
  input wire logic       bus_oe,
  input wire logic       frame_sync,
  input wire logic [7:0] seg_data,
  input wire logic [5:0] row_addr,
  input wire logic       display_off
);
  wire sel = chip_select_a && chip_select_b;
  wire st_rd = sel && !register_select && read_write && enable_strobe;

  // cycles since the last strobe falling edge, saturating
  logic       strobe_q;
  logic [7:0] since_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q   <= 1'b0;
      since_fall <= 8'hff;
    end else begin
      strobe_q <= enable_strobe;
      if (strobe_q && !enable_strobe) begin
        since_fall <= 8'h00;
      end else if (since_fall != 8'hff) begin
        since_fall <= since_fall + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pin_low;
    !reset_n_pin [*5];
  endsequence

  a_oe_decode: assert property (
    bus_oe == (sel && read_write && enable_strobe))
    else $error("bus_oe decode wrong");
  a_status_off: assert property (st_rd |-> bus_out[5] == display_off)
    else $error("status bit5 differs from off state");
  a_status_rst: assert property (s_pin_low ##0 st_rd |-> bus_out[4])
    else $error("status bit4 low while reset pin low");
  a_pin_off: assert property (s_pin_low |-> display_off)
    else $error("display not off under reset pin");
  a_pin_blank: assert property (s_pin_low |-> seg_data == 8'h00)
    else $error("segments not blank under reset pin");
  a_off_blank: assert property (display_off [*3] |-> seg_data == 8'h00)
    else $error("segments not blank while off");
  a_unsel_hold: assert property (
    (!sel && reset_n_pin) [*8] |-> $stable(display_off))
    else $error("state changed while unselected");
  a_rst_line0: assert property (
    (!reset_n_pin && frame_sync) [*6] |-> row_addr == 6'h00)
    else $error("row not preset to line zero");
  a_busy_clears: assert property (
    st_rd && (int'(since_fall) > OP_CYCLES + 1) |-> !bus_out[7])
    else $error("busy still set long after the last access");
endmodule

bind glhp_host_port glhp_host_port_sva #(.OP_CYCLES(OP_CYCLES)) sva_u (
  .clk             (clk),
  .rst_n           (rst_n),
  .reset_n_pin     (reset_n_pin),
  .chip_select_a   (chip_select_a),
  .chip_select_b   (chip_select_b),
  .register_select (register_select),
  .read_write      (read_write),
  .enable_strobe   (enable_strobe),
  .bus_out         (bus_out),
  .bus_oe          (bus_oe),
  .frame_sync      (frame_sync),
  .seg_data        (seg_data),
  .row_addr        (row_addr),
  .display_off     (display_off)
);

// >>> bench/tb_top.sv
// self-checking bench for the graphic lcd host port
`timescale 1ns/1ns
module tb_top;
  logic        clk, rst_n, reset_n_pin, column_order, frame_sync, ok;
  logic        chip_select_a, chip_select_b, register_select, read_write;
  logic        enable_strobe, bus_oe, display_off;
  logic [7:0]  bus_in, bus_out, seg_data, q;
  logic [5:0]  scan_col, row_addr;
  logic [2:0]  scan_page;
  logic [31:0] seed;
  int          mem[512];
  int          col, page, off, line, outr, rowm, n_errors, n_compared;

  glhp_host_port #(.OP_CYCLES(14)) dut_u (
    .clk             (clk),
    .rst_n           (rst_n),
    .reset_n_pin     (reset_n_pin),
    .chip_select_a   (chip_select_a),
    .chip_select_b   (chip_select_b),
    .register_select (register_select),
    .read_write      (read_write),
    .enable_strobe   (enable_strobe),
    .bus_in          (bus_in),
    .bus_out         (bus_out),
    .bus_oe          (bus_oe),
    .column_order    (column_order),
    .frame_sync      (frame_sync),
    .scan_page       (scan_page),
    .scan_col        (scan_col),
    .seg_data        (seg_data),
    .row_addr        (row_addr),
    .display_off     (display_off)
  );
  glhp_host_model host_u (
    .clk             (clk),
    .bus_out         (bus_out),
    .chip_select_a   (chip_select_a),
    .chip_select_b   (chip_select_b),
    .register_select (register_select),
    .read_write      (read_write),
    .enable_strobe   (enable_strobe),
    .bus_in          (bus_in)
  );

  always #25 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one host access, mirrored in the reference model
  task automatic op(input logic sel, input logic [1:0] a, input logic [7:0] d);
    if (sel && reset_n_pin && a != 2'b01) host_u.poll(ok);
    host_u.acc(sel, a[1], a[0], d, q);
    if (sel && a == 2'b01) chk(q & 8'h30, {2'b00, off[0], ~reset_n_pin, 4'h0});
    if (sel && reset_n_pin) begin
      case (a)
        2'b00: begin
          if (d[7:1] == 7'h1f) off = !d[0];
          else if (d[7:6] == 2'b01) col = d[5:0];
          else if (d[7:3] == 5'h17) page = d[2:0];
          else if (d[7:6] == 2'b11) line = d[5:0];
        end
        2'b10: mem[page * 64 + col] = d;
        2'b11: begin
          if (outr >= 0) chk(q, outr[7:0]);
          outr = mem[page * 64 + col];
        end
        default: ;
      endcase
      if (a[1]) col = (col + 1) % 64;
    end
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reset_n_pin = 1'b0;
    column_order = 1'b0;
    frame_sync = 1'b1;
    scan_page = 3'h0;
    scan_col = 6'h00;
    foreach (mem[i]) mem[i] = -1;
    off = 1;
    outr = -1;
    seed = 32'h000166c9;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    op(1'b1, 2'b00, 8'h3f);
    op(1'b1, 2'b01, 8'h00);
    chk({7'h0, display_off}, 8'h01);
    reset_n_pin <= 1'b1;
    op(1'b0, 2'b00, 8'h3f);
    chk({7'h0, display_off}, 8'h01);
    op(1'b1, 2'b00, 8'h3f);
    op(1'b1, 2'b01, 8'h00);
    chk({7'h0, display_off}, 8'h00);
    op(1'b1, 2'b00, 8'hbb);
    op(1'b1, 2'b00, 8'h7e);
    repeat (3) begin
      seed = lfsr(seed);
      op(1'b1, 2'b10, seed[7:0]);
    end
    op(1'b1, 2'b01, 8'h00);
    chk({7'h0, q[7]}, 8'h01);
    op(1'b1, 2'b00, 8'h7e);
    repeat (4) op(1'b1, 2'b11, 8'h00);
    scan_page <= 3'h3;
    scan_col <= 6'h3e;
    repeat (4) @(posedge clk);
    chk(seg_data, mem[254][7:0]);
    column_order <= 1'b1;
    scan_col <= 6'h01;
    repeat (4) @(posedge clk);
    chk(seg_data, mem[254][7:0]);
    op(1'b1, 2'b00, 8'h3e);
    repeat (3) @(posedge clk);
    chk(seg_data, 8'h00);
    seed = lfsr(seed);
    op(1'b1, 2'b00, {2'b11, seed[5:0]});
    repeat (4) @(posedge clk);
    chk({2'b00, row_addr}, {2'b00, line[5:0]});
    rowm = line;
    frame_sync <= 1'b0;
    op(1'b1, 2'b00, {2'b11, ~line[5:0]});
    chk({2'b00, row_addr}, rowm[7:0]);
    frame_sync <= 1'b1;
    repeat (2) @(posedge clk);
    chk({2'b00, row_addr}, line[7:0]);
    reset_n_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk({2'b00, row_addr}, 8'h00);
    chk(seg_data, 8'h00);
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report;
  end
endmodule
